// *** shared/scss_pkg.sv ***
package scss_pkg;
    // Byte addresses on the 32-bit register bus
    localparam logic [7:0] SCSS_ADDR_CLOCK_SOURCE_SELECT = 8'h8c;
    localparam logic [7:0] SCSS_ADDR_INT_OSC_CONTROL = 8'ha0;
    localparam logic [7:0] SCSS_ADDR_INT_OSC_COARSE_TRIM = 8'ha4;
    localparam logic [7:0] SCSS_ADDR_INT_OSC_FINE_TRIM = 8'h9c;
    localparam logic [7:0] SCSS_ADDR_EXT_OSC_CONTROL = 8'hb0;
    localparam logic [7:0] SCSS_ADDR_MULT_CONTROL = 8'hb4;
    localparam logic [7:0] SCSS_ADDR_IRQ_STATUS = 8'hc0;
    localparam logic [7:0] SCSS_ADDR_IRQ_MASK = 8'hc4;
    // Printed register offset kept as index
    localparam logic [7:0] SCSS_IDX_CLOCK_SOURCE_SELECT = 8'h8f;
    // Field positions
    localparam int SCSS_OSC_ENABLE_POS = 6;
    localparam int SCSS_OSC_SUSPEND_POS = 5;
    localparam int SCSS_OSC_READY_POS = 4;
    localparam int SCSS_EXT_ENABLE_POS = 0;
    localparam int SCSS_EXT_SETTLED_POS = 7;
    localparam int SCSS_MULT_ENABLE_POS = 0;
    localparam int SCSS_MULT_SRC_POS = 1;
    localparam int SCSS_MULT_X4_POS = 2;
    localparam int SCSS_MULT_SCALE_POS = 4;
    // Reset values
    localparam logic [1:0] SCSS_RST_SOURCE = 2'h0;
    localparam logic [2:0] SCSS_RST_DIVIDER = 3'h0;
    localparam logic [1:0] SCSS_RST_OSC_ENABLE = 2'h3;
    localparam logic [6:0] SCSS_RST_COARSE = 7'h40;
    localparam logic [5:0] SCSS_RST_FINE = 6'h20;
    // Crystal settle time and clock rate
    localparam int SCSS_CLK_HZ = 40_000_000;
    localparam int SCSS_XTAL_SETTLE_US = 1000;
    localparam int SCSS_XTAL_SETTLE_CYC = (SCSS_CLK_HZ / 1_000_000) * SCSS_XTAL_SETTLE_US;
    // Interrupt status bits
    localparam int SCSS_IRQ_WAKE = 0;
    localparam int SCSS_IRQ_SETTLED = 1;
    localparam int SCSS_IRQ_SWITCHED = 2;
    localparam int SCSS_IRQ_W = 3;

    typedef enum logic [1:0] {
        SCSS_SRC_INT = 2'b00,
        SCSS_SRC_EXT = 2'b01,
        SCSS_SRC_MULT = 2'b10,
        SCSS_SRC_RSVD = 2'b11
    } scss_src_e;

    typedef enum logic [1:0] {
        SCSS_ST_RUN = 2'b00,
        SCSS_ST_DRAIN = 2'b01,
        SCSS_ST_SUSPEND = 2'b10
    } scss_state_e;
endpackage

// *** shared/scss_tick_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// Rate source: one enable input, phase-aligned tick output
interface scss_tick_if;
    logic src_en;
    logic [3:0] ratio;
    logic run;
    logic tick;
    modport gen (input src_en, input ratio, input run, output tick);
    modport use_side (output src_en, output ratio, output run, input tick);
endinterface
`default_nettype wire

// *** tb/scss_ext_osc_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// External oscillator circuit: a crystal starts some cycles after power-up
module scss_ext_osc_model #(
    parameter int START_CYC = 5
) (
    input wire logic clk_i,
    input wire logic power_i,
    input wire logic crystal_i,
    output logic running_o,
    output logic crystal_mode_o
);
    int cnt;

    // Start-up count; RC and C modes would run at once
    always_ff @(posedge clk_i) begin
        if (!power_i) begin
            cnt <= 0;
        end else if (cnt < START_CYC) begin
            cnt <= cnt + 1;
        end
    end

    // Not running until the start-up time has passed, so a hasty select is seen
    assign running_o = power_i && (!crystal_i || cnt >= START_CYC);
    assign crystal_mode_o = crystal_i;
endmodule // scss_ext_osc_model
`default_nettype wire

// *** tb/tb_system_clock_select_suspend.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_system_clock_select_suspend import scss_pkg::*;;
    logic clk, rst, wb_we, wb_stb, wb_cyc, ack, ext_power, comp0_en, comp0_out;
    logic int_osc_en, ext_run, xtal_mode, sys_en, periph_en, halted, irq;
    logic [31:0] wb_adr, wb_wdat, wb_rdat;
    logic [3:0] wb_sel, port_match;
    logic [6:0] coarse;
    logic [5:0] fine;
    logic [1:0] act_src;
    logic [15:0] note;
    logic [15:0] note_q[$];
    int fail_count = 0;
    int comparisons = 0;
    int seed = 16002;

    always #12.5 clk = ~clk;

    scss_clock_select #(.XTAL_SETTLE_CYC(8)) dut (
        .clk_i(clk), .rst_i(rst), .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_we_i(wb_we), .wb_sel_i(wb_sel), .wb_stb_i(wb_stb),
        .wb_cyc_i(wb_cyc), .wb_ack_o(ack), .int_osc_en_i(int_osc_en),
        .ext_osc_en_i(ext_run), .crystal_mode_i(xtal_mode), .port_match_i(port_match),
        .comp0_enable_i(comp0_en), .comp0_out_i(comp0_out), .cal_coarse_i(coarse),
        .cal_fine_i(fine), .system_clock_en_o(sys_en), .periph_ext_clock_en_o(periph_en),
        .core_halted_o(halted), .active_source_o(act_src), .irq_o(irq)
    );

    scss_ext_osc_model #(.START_CYC(5)) ext_osc (
        .clk_i(clk), .power_i(ext_power), .crystal_i(1'b1),
        .running_o(ext_run), .crystal_mode_o(xtal_mode)
    );

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Classic single cycle; request held until ack is sampled high
    task automatic wb(input logic [7:0] a, input logic we, input logic [7:0] d);
        int n;
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_adr <= {24'h0, a};
        wb_we <= we;
        wb_wdat <= {24'h0, d};
        wb_sel <= 4'hf;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (ack !== 1'b1) begin
            fail_count++;
            wrap_up();
        end
    endtask

    // The note is queued before the request, so the watcher always finds it
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        note_q.push_back({m, e});
        wb(a, 1'b0, 8'h00);
    endtask

    task automatic wait_src(input logic [1:0] s);
        int n;
        n = 0;
        while (act_src !== s && n < 300) begin
            @(posedge clk);
            n++;
        end
        check("active_source", {30'h0, act_src}, {30'h0, s});
    endtask

    // Tick count over 256 cycles; a small slack covers divider phase
    task automatic measure(input int exp);
        int n;
        n = 0;
        repeat (256) begin
            @(posedge clk);
            if (sys_en === 1'b1) n++;
        end
        check("tick_count", {31'h0, (n >= exp - 2 && n <= exp + 2)}, 32'h1);
    endtask

    task automatic do_reset();
        rst <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask

    // Read watcher: oldest note against the data that comes with ack
    always @(posedge clk) begin
        if (ack === 1'b1 && wb_we === 1'b0 && note_q.size() > 0) begin
            note = note_q.pop_front();
            check("read_data", wb_rdat & {24'hffffff, note[15:8]}, {24'h0, note[7:0]});
        end
    end

    initial begin
        repeat (100000) @(posedge clk);
        fail_count++;
        wrap_up();
    end

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        {wb_we, wb_stb, wb_cyc, ext_power, comp0_en} = 5'h00;
        comp0_out = 1'b1;
        int_osc_en = 1'b1;
        wb_adr = 32'h0;
        wb_wdat = 32'h0;
        wb_sel = 4'h0;
        port_match = 4'h0;
        coarse = 7'($random(seed));
        fine = 6'($random(seed));
        do_reset();
        check("active_source", {30'h0, act_src}, 32'h0);
        rd(8'h8c, 8'hff, 8'h00);
        rd(8'ha0, 8'hef, 8'hc0);
        rd(8'ha4, 8'h7f, {1'b0, coarse});
        rd(8'h9c, 8'h3f, {2'b0, fine});
        // Every divider code, slowest first
        for (int c = 0; c < 8; c++) begin
            wb(8'ha0, 1'b1, {5'h18, 3'(c)});
            repeat (4) @(posedge clk);
            measure(2 << c);
        end
        // Crystal: wait past the settle time before the flag is trusted
        ext_power <= 1'b1;
        wb(8'hb0, 1'b1, 8'h01);
        repeat (40) @(posedge clk);
        rd(8'hb0, 8'h81, 8'h81);
        check("periph_ext", {31'h0, periph_en}, 32'h1);
        wb(8'h8c, 1'b1, 8'hfd);
        wait_src(2'b01);
        rd(8'hc0, 8'h06, 8'h06);
        rd(8'h8c, 8'hff, 8'h01);
        wb(8'h8c, 1'b1, 8'hff);
        repeat (4) @(posedge clk);
        check("active_source", {30'h0, act_src}, 32'h1);
        // Reset in mid-run from the external source
        do_reset();
        check("active_source", {30'h0, act_src}, 32'h0);
        rd(8'ha0, 8'h07, 8'h00);
        wb(8'ha0, 1'b1, 8'hc7);
        // Scale codes below 3 pass every tick, the rest pass 2 of n
        for (int n = 2; n < 8; n++) begin
            wb(8'hb4, 1'b1, {1'b0, 3'(n), 4'h1});
            wb(8'h8c, 1'b1, 8'h02);
            wait_src(2'b10);
            measure((n < 3) ? 256 : 512 / n);
            wb(8'h8c, 1'b1, 8'h00);
            wait_src(2'b00);
        end
        // Suspend and wake from each port, then the comparator; last one masked
        for (int k = 0; k < 5; k++) begin
            wb(8'hc0, 1'b1, 8'h07);
            wb(8'hc4, 1'b1, {7'h0, k != 4});
            // Firmware sets the suspend bit with oscillator enable kept at 11 and divider code 7
            wb(8'ha0, 1'b1, 8'he7);
            comp0_en <= 1'b1;
            repeat (6) @(posedge clk);
            check("halted", {31'h0, halted}, 32'h1);
            check("sys_tick", {31'h0, sys_en}, 32'h0);
            if (k < 4) port_match <= 4'(1 << k);
            else comp0_out <= 1'b0;
            for (int n = 0; n < 8 && halted !== 1'b0; n++) @(posedge clk);
            check("halted", {31'h0, halted}, 32'h0);
            port_match <= 4'h0;
            comp0_en <= 1'b0;
            comp0_out <= 1'b1;
            rd(8'hc0, 8'h01, 8'h01);
            rd(8'ha0, 8'h20, 8'h00);
            check("irq", {31'h0, irq}, {31'h0, k != 4});
            wb(8'hc0, 1'b1, 8'h07);
            repeat (3) @(posedge clk);
            check("irq", {31'h0, irq}, 32'h0);
        end
        rd(8'h10, 8'hff, 8'h00);
        repeat (4) @(posedge clk);
        wrap_up();
    end
endmodule // tb_system_clock_select_suspend
`default_nettype wire

// *** verilog/scss_clock_select.sv ***
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Source field picks internal scaled, external or multiplier; code 11 reserved.
// - External enable still reaches peripherals while internal clocks the system.
// - Internal source usable right after the write that enables it.
// - Hardware sets the crystal settled flag once settled.
// - Any reset returns the system clock to the internal oscillator.
// - Internal divided by 1 to 128 by divider field; resets to 128.
// - Trim registers load calibration values for a nominal 24 MHz base.
// - Multiplier passes its base enable unmultiplied (x4 bit only reads back), scaled by 1, 2/3 through 2/7.
// - Writing 1 to suspend halts the internal oscillator; sources fed by the external oscillator keep clocking the system.
// - Port 0..3 match or enabled comparator 0 low wakes the oscillator.
// - Wake resumes operation whether or not an interrupt follows.
// - Execution resumes after the write that set suspend.
// - Upper six bits of the source select register read zero, ignore writes.
module scss_clock_select import scss_pkg::*; #(
    parameter int XTAL_SETTLE_CYC = SCSS_XTAL_SETTLE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_stb_i,
    input wire logic wb_cyc_i,
    output logic wb_ack_o,
    input wire logic int_osc_en_i,
    input wire logic ext_osc_en_i,
    input wire logic crystal_mode_i,
    input wire logic [3:0] port_match_i,
    input wire logic comp0_enable_i,
    input wire logic comp0_out_i,
    input wire logic [6:0] cal_coarse_i,
    input wire logic [5:0] cal_fine_i,
    output logic system_clock_en_o,
    output logic periph_ext_clock_en_o,
    output logic core_halted_o,
    output logic [1:0] active_source_o,
    output logic irq_o
);
    // A zero settle count would leave the settled flag stuck low
    if (XTAL_SETTLE_CYC < 1) begin : g_bad_settle
        $error("XTAL_SETTLE_CYC must be at least 1");
    end

    logic [1:0] source_reg;
    logic [2:0] divider_reg;
    logic [1:0] osc_enable_reg;
    logic suspend_reg;
    logic [6:0] coarse_reg;
    logic [5:0] fine_reg;
    logic ext_enable_reg;
    logic settled_reg;
    logic [31:0] settle_cnt_reg;
    logic mult_enable_reg;
    logic mult_src_reg;
    logic mult_x4_reg;
    logic [2:0] mult_scale_reg;
    logic [2:0] mult_phase_reg;
    logic [SCSS_IRQ_W-1:0] status_reg;
    logic [SCSS_IRQ_W-1:0] mask_reg;
    logic [1:0] active_reg;
    scss_state_e state_reg;
    logic ack_reg;
    logic [31:0] dat_reg;
    logic sys_en_reg;
    logic per_en_reg;
    logic halted_reg;
    logic irq_reg;
    logic cal_loaded_reg;

    // Bus decode; a request is answered one cycle after it is seen
    logic req;
    logic wr;
    logic wr_lo;
    logic hit_src;
    logic hit_osc;
    logic hit_crs;
    logic hit_fin;
    logic hit_ext;
    logic hit_mul;
    logic hit_sts;
    logic hit_msk;
    assign req = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wr = req && wb_we_i;
    assign wr_lo = wr && wb_sel_i[0];
    assign hit_src = (wb_adr_i[7:0] == SCSS_ADDR_CLOCK_SOURCE_SELECT);
    assign hit_osc = (wb_adr_i[7:0] == SCSS_ADDR_INT_OSC_CONTROL);
    assign hit_crs = (wb_adr_i[7:0] == SCSS_ADDR_INT_OSC_COARSE_TRIM);
    assign hit_fin = (wb_adr_i[7:0] == SCSS_ADDR_INT_OSC_FINE_TRIM);
    assign hit_ext = (wb_adr_i[7:0] == SCSS_ADDR_EXT_OSC_CONTROL);
    assign hit_mul = (wb_adr_i[7:0] == SCSS_ADDR_MULT_CONTROL);
    assign hit_sts = (wb_adr_i[7:0] == SCSS_ADDR_IRQ_STATUS);
    assign hit_msk = (wb_adr_i[7:0] == SCSS_ADDR_IRQ_MASK);

    // Wake causes, evaluated every cycle while suspended
    logic wake;
    assign wake = (|port_match_i) || (comp0_enable_i && !comp0_out_i);

    // Internal oscillator is alive unless disabled or suspended
    logic int_alive;
    assign int_alive = (osc_enable_reg == SCSS_RST_OSC_ENABLE) && int_osc_en_i && !suspend_reg;

    // Divided internal rate from the shared divider module
    scss_tick_if int_tick_if ();
    assign int_tick_if.src_en = int_alive;
    assign int_tick_if.ratio = {1'b0, 3'(3'h7 - divider_reg)};
    assign int_tick_if.run = 1'b1;
    scss_divider u_int_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .port_if(int_tick_if)
    );

    // External rate is usable once enabled and, for a crystal, settled
    logic ext_alive;
    assign ext_alive = ext_enable_reg && ext_osc_en_i && (!crystal_mode_i || settled_reg);

    // Multiplier: base enable of the chosen source, x4 bit unused; scale by 2/n gates phases
    logic mult_base;
    logic [2:0] mult_n;
    logic mult_pass;
    logic mult_alive;
    assign mult_base = mult_src_reg ? ext_alive : int_alive;
    assign mult_alive = mult_enable_reg && mult_base;
    assign mult_n = (mult_scale_reg < 3'h3) ? 3'h1 : mult_scale_reg;
    assign mult_pass = (mult_n == 3'h1) || (mult_phase_reg < 3'h2);

    // Selected tick and whether the chosen source can run at all
    logic sel_tick;
    logic sel_ready;
    always_comb begin
        unique case (scss_src_e'(active_reg))
            SCSS_SRC_INT: begin
                sel_tick = int_tick_if.tick;
                sel_ready = int_alive;
            end
            SCSS_SRC_EXT: begin
                sel_tick = ext_alive;
                sel_ready = ext_alive;
            end
            SCSS_SRC_MULT: begin
                sel_tick = mult_alive && mult_pass;
                sel_ready = mult_alive;
            end
            default: begin
                sel_tick = 1'b0;
                sel_ready = 1'b0;
            end
        endcase
    end

    // Pending switch waits for an idle cycle; a source that never idles drains after a tick
    logic switch_due;
    assign switch_due = (source_reg != active_reg) && (source_reg != SCSS_SRC_RSVD);

    // Crystal settle counter: flag rises only after the full settle time
    always_ff @(posedge clk_i) begin
        if (rst_i || !(ext_enable_reg && ext_osc_en_i && crystal_mode_i)) begin
            settle_cnt_reg <= 32'h0;
            settled_reg <= 1'b0;
        end else if (settle_cnt_reg >= 32'(XTAL_SETTLE_CYC - 1)) begin
            settled_reg <= 1'b1;
        end else begin
            settle_cnt_reg <= settle_cnt_reg + 32'h1;
        end
    end

    // Multiplier phase walks 0..n-1 on each base enable
    always_ff @(posedge clk_i) begin
        if (rst_i || !mult_alive) begin
            mult_phase_reg <= 3'h0;
        end else begin
            mult_phase_reg <= (mult_phase_reg >= 3'(mult_n - 3'h1)) ? 3'h0
                : 3'(mult_phase_reg + 3'h1);
        end
    end

    // Calibration is taken from the trim inputs once, in the cycle after reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cal_loaded_reg <= 1'b0;
        end else begin
            cal_loaded_reg <= 1'b1;
        end
    end

    // Register writes; the upper bits of source select are simply dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            source_reg <= SCSS_RST_SOURCE;
            divider_reg <= SCSS_RST_DIVIDER;
            osc_enable_reg <= SCSS_RST_OSC_ENABLE;
            coarse_reg <= SCSS_RST_COARSE;
            fine_reg <= SCSS_RST_FINE;
            ext_enable_reg <= 1'b0;
            mult_enable_reg <= 1'b0;
            mult_src_reg <= 1'b0;
            mult_x4_reg <= 1'b0;
            mult_scale_reg <= 3'h0;
            mask_reg <= '0;
        end else begin
            if (!cal_loaded_reg) begin
                coarse_reg <= cal_coarse_i;
                fine_reg <= cal_fine_i;
            end else if (wr_lo && hit_crs) begin
                coarse_reg <= wb_dat_i[6:0];
            end else if (wr_lo && hit_fin) begin
                fine_reg <= wb_dat_i[5:0];
            end
            if (wr_lo && hit_src) begin
                source_reg <= wb_dat_i[1:0];
            end
            if (wr_lo && hit_osc) begin
                osc_enable_reg <= wb_dat_i[SCSS_OSC_ENABLE_POS +: 2];
                divider_reg <= wb_dat_i[2:0];
            end
            if (wr_lo && hit_ext) begin
                ext_enable_reg <= wb_dat_i[SCSS_EXT_ENABLE_POS];
            end
            if (wr_lo && hit_mul) begin
                mult_enable_reg <= wb_dat_i[SCSS_MULT_ENABLE_POS];
                mult_src_reg <= wb_dat_i[SCSS_MULT_SRC_POS];
                mult_x4_reg <= wb_dat_i[SCSS_MULT_X4_POS];
                mult_scale_reg <= wb_dat_i[SCSS_MULT_SCALE_POS +: 3];
            end
            if (wr_lo && hit_msk) begin
                mask_reg <= wb_dat_i[SCSS_IRQ_W-1:0];
            end
        end
    end

    // Suspend state machine; suspend bit self-clears on wake
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= SCSS_ST_RUN;
            suspend_reg <= 1'b0;
            active_reg <= SCSS_RST_SOURCE;
        end else begin
            unique case (state_reg)
                SCSS_ST_RUN: begin
                    if (wr_lo && hit_osc && wb_dat_i[SCSS_OSC_SUSPEND_POS]) begin
                        suspend_reg <= 1'b1;
                        state_reg <= SCSS_ST_SUSPEND;
                    end else if (switch_due && (!sel_tick || sys_en_reg)) begin
                        state_reg <= SCSS_ST_DRAIN;
                    end
                end
                SCSS_ST_DRAIN: begin
                    active_reg <= source_reg;
                    state_reg <= SCSS_ST_RUN;
                end
                SCSS_ST_SUSPEND: begin
                    if (wake) begin
                        suspend_reg <= 1'b0;
                        state_reg <= SCSS_ST_RUN;
                    end
                end
                default: begin
                    state_reg <= SCSS_ST_RUN;
                end
            endcase
        end
    end

    // Sticky events; a set in the clearing cycle wins
    logic [SCSS_IRQ_W-1:0] ev;
    logic [SCSS_IRQ_W-1:0] clr;
    assign ev = {state_reg == SCSS_ST_DRAIN,
                 (settle_cnt_reg == 32'(XTAL_SETTLE_CYC - 1)) && !settled_reg,
                 state_reg == SCSS_ST_SUSPEND && wake};
    assign clr = (wr_lo && hit_sts) ? wb_dat_i[SCSS_IRQ_W-1:0] : '0;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_reg <= '0;
        end else begin
            status_reg <= (status_reg & ~clr) | ev;
        end
    end

    // Read mux, unmapped addresses read zero and still ack
    logic [31:0] rd;
    always_comb begin
        rd = 32'h0;
        if (hit_src) rd = {30'h0, source_reg};
        if (hit_osc) rd = {24'h0, osc_enable_reg, suspend_reg, int_alive, 1'b0, divider_reg};
        if (hit_crs) rd = {25'h0, coarse_reg};
        if (hit_fin) rd = {26'h0, fine_reg};
        if (hit_ext) rd = {24'h0, settled_reg, 6'h0, ext_enable_reg};
        if (hit_mul) rd = {25'h0, mult_scale_reg, 1'b0, mult_x4_reg, mult_src_reg,
                           mult_enable_reg};
        if (hit_sts) rd = {29'h0, status_reg};
        if (hit_msk) rd = {29'h0, mask_reg};
    end

    // Bus response and registered outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0;
            sys_en_reg <= 1'b0;
            per_en_reg <= 1'b0;
            halted_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            ack_reg <= req;
            dat_reg <= req ? rd : 32'h0;
            sys_en_reg <= sel_tick && sel_ready && state_reg != SCSS_ST_DRAIN;
            per_en_reg <= ext_alive;
            halted_reg <= (state_reg == SCSS_ST_SUSPEND) && (active_reg == SCSS_SRC_INT);
            irq_reg <= |(status_reg & mask_reg);
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign system_clock_en_o = sys_en_reg;
    assign periph_ext_clock_en_o = per_en_reg;
    assign core_halted_o = halted_reg;
    assign active_source_o = active_reg;
    assign irq_o = irq_reg;

    AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
    AST_SUSPEND_HALTS: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_reg == SCSS_ST_SUSPEND && active_reg == SCSS_SRC_INT) |=> !system_clock_en_o)
        else $error("clock ran while suspended");
    AST_WAKE_EXIT: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_reg == SCSS_ST_SUSPEND && wake) |=> state_reg == SCSS_ST_RUN && !suspend_reg)
        else $error("wake not honoured");
    AST_NO_WAKE_STAY: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_reg == SCSS_ST_SUSPEND && !wake) |=> state_reg == SCSS_ST_SUSPEND)
        else $error("left suspend without wake");
    AST_RESET_SRC: assert property (@(posedge clk_i)
        $past(rst_i) |-> active_reg == SCSS_SRC_INT && divider_reg == SCSS_RST_DIVIDER)
        else $error("reset source wrong");
    AST_UPPER_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !wb_we_i && hit_src) |=> wb_dat_o[31:2] == 30'h0)
        else $error("upper select bits not zero");
    AST_SWITCH_SAFE: assert property (@(posedge clk_i) disable iff (rst_i)
        $changed(active_reg) |-> $past(state_reg) == SCSS_ST_DRAIN)
        else $error("switch without drain");
    AST_SETTLE: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(settled_reg) |-> $past(settle_cnt_reg) == 32'(XTAL_SETTLE_CYC - 1))
        else $error("settled early");
    AST_PERIPH_EXT: assert property (@(posedge clk_i) disable iff (rst_i)
        ext_alive |=> periph_ext_clock_en_o) else $error("peripheral clock lost");
endmodule // scss_clock_select
`default_nettype wire

// *** verilog/scss_divider.sv ***
`timescale 1ns/1ps
`default_nettype none
// Divides incoming source enables by 2^ratio; ratio 0 passes every enable
module scss_divider (
    input wire logic clk_i,
    input wire logic rst_i,
    scss_tick_if.gen port_if
);
    logic [7:0] cnt_reg;
    logic [7:0] limit;
    logic wrap;

    // Limit is 2^ratio - 1, so only power-of-two steps exist
    assign limit = 8'((9'h1 << port_if.ratio[2:0]) - 9'h1);
    assign wrap = (cnt_reg >= limit);

    // Counter only moves on source enables, and clears while not running
    always_ff @(posedge clk_i) begin
        if (rst_i || !port_if.run) begin
            cnt_reg <= 8'h00;
            port_if.tick <= 1'b0;
        end else begin
            port_if.tick <= port_if.src_en && wrap;
            if (port_if.src_en) begin
                cnt_reg <= wrap ? 8'h00 : 8'(cnt_reg + 8'h01);
            end
        end
    end
endmodule // scss_divider
`default_nettype wire
